// *** verilog/reset_seq_pkg.sv ***
/*
 * Constants for the reset and start-up sequencer: clock modes, time-outs,
 * speed-switch counts and status reset values.
 * Assumes a 50 MHz REF_CLK drives the sequencer.
 */
package reset_seq_pkg;
	typedef enum logic [2:0] {
		low_power_crystal_mode = 3'h0,
		crystal_mode = 3'h1,
		high_speed_crystal_mode = 3'h2,
		external_clock_mode = 3'h3,
		internal_clock_mode = 3'h4,
		internal_clock_out_mode = 3'h5,
		resistor_capacitor_mode = 3'h6,
		resistor_capacitor_out_mode = 3'h7
	} osc_mode_type;

	typedef enum logic [2:0] {
		st_reset = 3'h0,
		st_power_timer = 3'h1,
		st_crystal_timer = 3'h3,
		st_wait_clear = 3'h2,
		st_run = 3'h6
	} seq_state_type;

	localparam int REF_CLK_HZ = 50000000;
	localparam int POWERUP_TIME_MS = 72;
	localparam int POWERUP_CYCLES = REF_CLK_HZ / 1000 * POWERUP_TIME_MS;
	localparam int CRYSTAL_START_COUNT = 1024;
	localparam int FAST_CLOCK_HZ = 4000000;
	localparam int SLOW_CLOCK_HZ = 48000;
	localparam int FAST_DIVIDE = REF_CLK_HZ / FAST_CLOCK_HZ;
	localparam int SLOW_DIVIDE = REF_CLK_HZ / SLOW_CLOCK_HZ;
	localparam int OLD_SPEED_PULSES = 2;
	localparam int NEW_SPEED_PULSES = 8;
	localparam int CLOCK_OUT_DIVIDE = 4;
	localparam int GLITCH_FILTER_CYCLES = 100;
	localparam int BROWNOUT_MIN_CYCLES = 5000;
	localparam logic POWER_ON_STATUS_RESET = 1'h0;
	localparam logic EXPIRED_RESET = 1'h1;
	localparam logic SLEEP_RESET = 1'h1;
	localparam logic SPEED_RESET = 1'h1;
endpackage

// *** verilog/pulse_filter.sv ***
/*
 * Pulse filter: output follows the input only after it has held a new
 * level for a set number of cycles.
 * Assumes the input is already synchronised to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pulse_filter #(
	parameter int HOLD_CYCLES = 100,
	parameter logic INIT = 1'h0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic level_in,
	output logic level_out
);
	localparam int CW = $clog2(HOLD_CYCLES + 1);
	logic [CW-1:0] count;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			count <= '0;
			level_out <= INIT;
		end
		else if (level_in == level_out)
			count <= '0;
		else if (count == CW'(HOLD_CYCLES - 1))
		begin
			count <= '0;
			level_out <= level_in;
		end
		else
			count <= count + 1'b1;
	end
endmodule
`default_nettype wire

// *** verilog/reset_timeout_sequencer.sv ***
/*
 * Reset and start-up sequencer: reset causes, status flags, power-up and
 * crystal start-up timers, dual-speed clock enable and clock output.
 * Assumes analogue detectors and pins arrive asynchronously, and that the
 * fast/slow internal rates are produced as enables from REF_CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_timeout_sequencer
	import reset_seq_pkg::*;
#(
	parameter int POWERUP_COUNT = POWERUP_CYCLES,
	parameter int BROWNOUT_COUNT = BROWNOUT_MIN_CYCLES,
	parameter int FILTER_COUNT = GLITCH_FILTER_CYCLES
) (
	// clock and power-on reset
	input wire logic REF_CLK,
	input wire logic RST,
	// analogue detectors and pins
	input wire logic SUPPLY_ABOVE_THRESHOLD,
	input wire logic MASTER_CLEAR_PIN_N,
	input wire logic OSCILLATOR_INPUT_PIN,
	// watchdog and sleep events
	input wire logic WATCHDOG_TIMEOUT,
	input wire logic SLEEP_ACTIVE,
	input wire logic SLEEP_WAKE,
	// configuration word
	input wire logic [2:0] OSCILLATOR_SELECT_BITS,
	input wire logic POWERUP_TIMER_DISABLE_N,
	input wire logic BROWNOUT_ENABLE,
	// software writes to status bits
	input wire logic SPEED_SELECT_WRITE,
	input wire logic SPEED_SELECT_VALUE,
	input wire logic STATUS_WRITE,
	input wire logic POWER_ON_STATUS_VALUE,
	input wire logic BROWNOUT_STATUS_VALUE,
	// reset and clock outputs
	output logic CHIP_RESET,
	output logic REGISTER_RESET,
	output logic SYSTEM_CLOCK_EN,
	output logic OSCILLATOR_OUTPUT_PIN,
	output logic OSCILLATOR_OUTPUT_EN,
	// status
	output logic SPEED_SELECT_FLAG,
	output logic POWER_ON_STATUS,
	output logic BROWNOUT_STATUS,
	output logic WATCHDOG_EXPIRED_FLAG,
	output logic SLEEP_ENTERED_FLAG,
	output logic [2:0] RESET_CAUSE
);
	localparam int PW = $clog2(POWERUP_COUNT + 1);
	localparam int BW = $clog2(BROWNOUT_COUNT + 1);
	localparam int DW = $clog2(SLOW_DIVIDE + 1);

	function automatic logic is_crystal(input logic [2:0] m);
		return m == low_power_crystal_mode || m == crystal_mode ||
			m == high_speed_crystal_mode;
	endfunction

	function automatic logic is_internal(input logic [2:0] m);
		return m == internal_clock_mode || m == internal_clock_out_mode;
	endfunction

	// synchronisers
	logic [1:0] supply_sync, clear_sync, osc_sync;
	logic osc_prev;
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			supply_sync <= 2'h0;
			clear_sync <= 2'h0;
			osc_sync <= 2'h0;
			osc_prev <= 1'h0;
		end
		else
		begin
			supply_sync <= {supply_sync[0], SUPPLY_ABOVE_THRESHOLD};
			clear_sync <= {clear_sync[0], MASTER_CLEAR_PIN_N};
			osc_sync <= {osc_sync[0], OSCILLATOR_INPUT_PIN};
			osc_prev <= osc_sync[1];
		end
	end
	wire logic osc_rise = osc_sync[1] & ~osc_prev;

	logic clear_n;
	pulse_filter #(.HOLD_CYCLES(FILTER_COUNT), .INIT(1'h0)) clear_filter (
		.clk(REF_CLK),
		.rst(RST),
		.level_in(clear_sync[1]),
		.level_out(clear_n)
	);

	// brown-out detect: low supply must persist for the minimum duration
	logic [BW-1:0] low_count;
	logic brownout;
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			low_count <= '0;
			brownout <= 1'h0;
		end
		else if (!BROWNOUT_ENABLE || supply_sync[1])
		begin
			low_count <= '0;
			brownout <= 1'h0;
		end
		else if (low_count == BW'(BROWNOUT_COUNT - 1))
			brownout <= 1'h1;
		else
			low_count <= low_count + 1'b1;
	end

	// reset sequence; RST is the supply-rise power-on pulse
	seq_state_type state;
	logic [PW-1:0] pw_count;
	logic [10:0] xt_count;
	logic from_power_on, wake_pending, sleeping;
	wire logic pw_on = !POWERUP_TIMER_DISABLE_N;
	wire logic xt_on = is_crystal(OSCILLATOR_SELECT_BITS);
	wire logic wd_reset = WATCHDOG_TIMEOUT && !sleeping;

	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			state <= st_reset;
			pw_count <= '0;
			xt_count <= 11'h0;
			from_power_on <= 1'h1;
			wake_pending <= 1'h0;
		end
		else if (brownout)
		begin
			state <= st_reset;
			pw_count <= '0;
			xt_count <= 11'h0;
			from_power_on <= 1'h0;
		end
		else
		begin
			unique case (state)
				st_reset:
					if (supply_sync[1] || !BROWNOUT_ENABLE)
					begin
						pw_count <= '0;
						xt_count <= 11'h0;
						if (pw_on && (from_power_on || BROWNOUT_ENABLE))
							state <= st_power_timer;
						else if (xt_on && from_power_on)
							state <= st_crystal_timer;
						else
							state <= st_wait_clear;
					end
				st_power_timer:
					if (pw_count == PW'(POWERUP_COUNT - 1))
						state <= (xt_on && from_power_on) ?
							st_crystal_timer : st_wait_clear;
					else
						pw_count <= pw_count + 1'b1;
				st_crystal_timer:
					if (xt_count == 11'(CRYSTAL_START_COUNT))
						state <= st_wait_clear;
					else if (osc_rise)
						xt_count <= xt_count + 1'b1;
				st_wait_clear:
					if (clear_n)
						state <= st_run;
				st_run:
					if (!clear_n || wd_reset)
					begin
						state <= st_wait_clear;
						from_power_on <= 1'h0;
					end
					else if (SLEEP_WAKE && xt_on)
					begin
						state <= st_crystal_timer;
						xt_count <= 11'h0;
						wake_pending <= 1'h1;
					end
				default:
					state <= st_reset;
			endcase
			if (state == st_wait_clear && clear_n)
				wake_pending <= 1'h0;
		end
	end

	wire logic held = (state != st_run);

	// reset cause and status flags
	logic prev_held;
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			sleeping <= 1'h0;
			prev_held <= 1'h1;
			RESET_CAUSE <= 3'h0;
			WATCHDOG_EXPIRED_FLAG <= EXPIRED_RESET;
			SLEEP_ENTERED_FLAG <= SLEEP_RESET;
			POWER_ON_STATUS <= POWER_ON_STATUS_RESET;
			BROWNOUT_STATUS <= 1'h0;
			REGISTER_RESET <= 1'h1;
		end
		else
		begin
			prev_held <= held;
			REGISTER_RESET <= held && !wake_pending;
			if (state == st_run && SLEEP_ACTIVE)
			begin
				sleeping <= 1'h1;
				SLEEP_ENTERED_FLAG <= 1'h0;
			end
			if (brownout)
			begin
				BROWNOUT_STATUS <= 1'h0;
				RESET_CAUSE <= 3'h5;
				sleeping <= 1'h0;
			end
			else if (state == st_run && WATCHDOG_TIMEOUT)
			begin
				WATCHDOG_EXPIRED_FLAG <= 1'h0;
				RESET_CAUSE <= sleeping ? 3'h4 : 3'h3;
				sleeping <= 1'h0;
			end
			else if (state == st_run && !clear_n)
			begin
				RESET_CAUSE <= sleeping ? 3'h2 : 3'h1;
				if (sleeping)
				begin
					WATCHDOG_EXPIRED_FLAG <= 1'h1;
					SLEEP_ENTERED_FLAG <= 1'h0;
				end
				sleeping <= 1'h0;
			end
			else if (state == st_run && SLEEP_WAKE)
				sleeping <= 1'h0;
			else if (STATUS_WRITE)
			begin
				POWER_ON_STATUS <= POWER_ON_STATUS_VALUE;
				BROWNOUT_STATUS <= BROWNOUT_STATUS_VALUE;
			end
		end
	end

	// dual-speed internal clock enable with halted transition
	logic [DW-1:0] div_count;
	logic fast, target;
	logic switching;
	logic [3:0] pulse_count;
	wire logic [DW-1:0] div_end = fast ? DW'(FAST_DIVIDE - 1) :
		DW'(SLOW_DIVIDE - 1);
	wire logic tick = (div_count == div_end);

	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
			target <= SPEED_RESET;
		else if (held && !wake_pending)
			target <= SPEED_RESET;
		else if (SPEED_SELECT_WRITE && is_internal(OSCILLATOR_SELECT_BITS))
			target <= SPEED_SELECT_VALUE;
	end

	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			div_count <= '0;
			fast <= SPEED_RESET;
			switching <= 1'h0;
			pulse_count <= 4'h0;
		end
		else
		begin
			div_count <= tick ? '0 : div_count + 1'b1;
			if (!switching && target != fast)
			begin
				switching <= 1'h1;
				pulse_count <= 4'h0;
			end
			else if (switching && tick)
			begin
				if (pulse_count == 4'(OLD_SPEED_PULSES - 1))
				begin
					fast <= target;
					div_count <= '0;
				end
				if (pulse_count == 4'(OLD_SPEED_PULSES + NEW_SPEED_PULSES - 1))
					switching <= 1'h0;
				pulse_count <= pulse_count + 1'b1;
			end
		end
	end

	// system clock enable and clock output
	logic [1:0] out_div;
	wire logic rc_out = (OSCILLATOR_SELECT_BITS == resistor_capacitor_out_mode)
		|| (OSCILLATOR_SELECT_BITS == internal_clock_out_mode);
	wire logic sys_tick = is_internal(OSCILLATOR_SELECT_BITS) ? tick : osc_rise;
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			out_div <= 2'h0;
			SYSTEM_CLOCK_EN <= 1'h0;
			OSCILLATOR_OUTPUT_PIN <= 1'h0;
			OSCILLATOR_OUTPUT_EN <= 1'h0;
			SPEED_SELECT_FLAG <= SPEED_RESET;
			CHIP_RESET <= 1'h1;
		end
		else
		begin
			CHIP_RESET <= held;
			SPEED_SELECT_FLAG <= target;
			SYSTEM_CLOCK_EN <= sys_tick && !switching && !held;
			OSCILLATOR_OUTPUT_EN <= rc_out;
			if (sys_tick && !switching)
			begin
				out_div <= out_div + 1'b1;
				if (out_div == 2'(CLOCK_OUT_DIVIDE / 2 - 1) || out_div == 2'h3)
					OSCILLATOR_OUTPUT_PIN <= ~OSCILLATOR_OUTPUT_PIN;
			end
		end
	end
endmodule
`default_nettype wire

// *** test/reset_seq_sva.sv ***
/*
 * Port checker for the reset and start-up sequencer.
 * Assumes it is bound to reset_timeout_sequencer and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_seq_sva (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// stimulus
	input wire logic SUPPLY_ABOVE_THRESHOLD,
	input wire logic MASTER_CLEAR_PIN_N,
	input wire logic WATCHDOG_TIMEOUT,
	input wire logic [2:0] OSCILLATOR_SELECT_BITS,
	input wire logic SPEED_SELECT_WRITE,
	input wire logic SPEED_SELECT_VALUE,
	// results
	input wire logic CHIP_RESET,
	input wire logic REGISTER_RESET,
	input wire logic SYSTEM_CLOCK_EN,
	input wire logic OSCILLATOR_OUTPUT_EN,
	input wire logic SPEED_SELECT_FLAG,
	input wire logic POWER_ON_STATUS,
	input wire logic WATCHDOG_EXPIRED_FLAG,
	input wire logic SLEEP_ENTERED_FLAG,
	input wire logic [2:0] RESET_CAUSE
);
	wire [2:0] mode = OSCILLATOR_SELECT_BITS;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	chk_por_flags: assert property ($fell(RST) |-> CHIP_RESET &&
		REGISTER_RESET && WATCHDOG_EXPIRED_FLAG && SLEEP_ENTERED_FLAG &&
		!POWER_ON_STATUS && RESET_CAUSE == 3'h0)
		else $error("power-on flags wrong");
	chk_low_supply: assert property (
		(CHIP_RESET && !SUPPLY_ABOVE_THRESHOLD)[*3] |=> CHIP_RESET)
		else $error("left reset with supply low");
	chk_clear_held: assert property (
		(CHIP_RESET && !MASTER_CLEAR_PIN_N)[*3] |=> CHIP_RESET)
		else $error("left reset with clear pin low");
	chk_clock_output_enable: assert property (!$past(RST) &&
		$stable(mode) |-> OSCILLATOR_OUTPUT_EN == (mode[2] & mode[0]))
		else $error("clock output enable wrong");
	chk_tick_gap: assert property (
		SYSTEM_CLOCK_EN |=> (!SYSTEM_CLOCK_EN)[*8])
		else $error("system ticks too close");
	chk_no_tick_reset: assert property (
		CHIP_RESET && $past(CHIP_RESET) |-> !SYSTEM_CLOCK_EN)
		else $error("tick while in reset");
	chk_switch_halt: assert property (SPEED_SELECT_WRITE &&
		SPEED_SELECT_VALUE != SPEED_SELECT_FLAG && mode[2:1] == 2'h2 &&
		!CHIP_RESET |=> ##2 (!SYSTEM_CLOCK_EN)[*8])
		else $error("clock not halted on speed change");
	chk_write_refused: assert property (SPEED_SELECT_WRITE &&
		mode[2:1] != 2'h2 && !CHIP_RESET |=> $stable(SPEED_SELECT_FLAG))
		else $error("speed write taken outside internal mode");
	chk_wdt_reset: assert property (WATCHDOG_TIMEOUT &&
		SLEEP_ENTERED_FLAG && !CHIP_RESET |-> ##[1:4] (CHIP_RESET &&
		REGISTER_RESET && RESET_CAUSE == 3'h3 && !WATCHDOG_EXPIRED_FLAG))
		else $error("watchdog reset wrong");

	cover property ($fell(CHIP_RESET));
	cover property (SPEED_SELECT_WRITE && mode == 3'h4);
	cover property (RESET_CAUSE == 3'h5);
endmodule
bind reset_timeout_sequencer reset_seq_sva i_reset_seq_sva (.*);
`default_nettype wire

// *** test/supply_pin_model.sv ***
/*
 * Far side: supply monitor, master-clear pin and a free-running oscillator.
 * Assumes the bench sets the supply and pin levels.
 */
`timescale 1ns/1ps
`default_nettype none
module supply_pin_model (
	// levels from the bench
	input wire logic supply_ok,
	input wire logic clear_n,
	// pins toward the sequencer
	output logic supply_above,
	output logic clear_pin_n,
	output logic osc_pin
);
	// 2.5 MHz oscillator, twenty reference cycles a period
	initial osc_pin = 1'h0;
	always #200 osc_pin = ~osc_pin;
	assign supply_above = supply_ok;
	assign clear_pin_n = clear_n;
endmodule
`default_nettype wire

// *** test/reset_timeout_sequencer_tb.sv ***
/*
 * Self-checking bench for the reset and start-up sequencer.
 * Assumes the supply_pin_model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_timeout_sequencer_tb;
	import reset_seq_pkg::*;
	localparam int PU = 20;
	localparam int OSC = 20;
	logic REF_CLK = 0, RST = 1, supply_ok = 1, clear_n = 1;
	logic SUPPLY_ABOVE_THRESHOLD, MASTER_CLEAR_PIN_N, OSCILLATOR_INPUT_PIN;
	logic WATCHDOG_TIMEOUT = 0, SLEEP_ACTIVE = 0, SLEEP_WAKE = 0;
	logic [2:0] OSCILLATOR_SELECT_BITS = 3'h6;
	logic POWERUP_TIMER_DISABLE_N = 1, BROWNOUT_ENABLE = 0;
	logic SPEED_SELECT_WRITE = 0, SPEED_SELECT_VALUE = 1, STATUS_WRITE = 0;
	logic POWER_ON_STATUS_VALUE = 0, BROWNOUT_STATUS_VALUE = 0;
	logic CHIP_RESET, REGISTER_RESET, SYSTEM_CLOCK_EN, OSCILLATOR_OUTPUT_PIN;
	logic OSCILLATOR_OUTPUT_EN, SPEED_SELECT_FLAG, POWER_ON_STATUS;
	logic BROWNOUT_STATUS, WATCHDOG_EXPIRED_FLAG, SLEEP_ENTERED_FLAG;
	logic [2:0] RESET_CAUSE;
	int error_cnt = 0;
	int num_checks = 0;
	int n;

	always #10 REF_CLK = ~REF_CLK;

	supply_pin_model i_supply_pin_model (
		.supply_ok(supply_ok),
		.clear_n(clear_n),
		.supply_above(SUPPLY_ABOVE_THRESHOLD),
		.clear_pin_n(MASTER_CLEAR_PIN_N),
		.osc_pin(OSCILLATOR_INPUT_PIN)
	);

	reset_timeout_sequencer #(
		.POWERUP_COUNT(PU),
		.BROWNOUT_COUNT(4),
		.FILTER_COUNT(3)
	) i_reset_timeout_sequencer (.*);

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic chk_n(string what, int got, int lo, int hi);
		num_checks++;
		if (got < lo || got > hi)
		begin
			error_cnt++;
			$display("unexpected %s: expected %0d..%0d, seen %0d", what, lo,
				hi, got);
		end
	endtask

	task automatic cycles(int k);
		repeat (k) @(negedge REF_CLK);
	endtask

	// counts cycles until out of reset, or until the next system tick
	task automatic wait_for(logic tick, output int k);
		k = 0;
		do
		begin
			@(negedge REF_CLK);
			k++;
		end
		while ((tick ? SYSTEM_CLOCK_EN !== 1 : CHIP_RESET !== 0) && k < 30000);
		if (k >= 30000)
		begin
			error_cnt++;
			end_of_test();
		end
	endtask

	task automatic power_on(logic [2:0] mode, logic dis_n);
		RST = 1;
		OSCILLATOR_SELECT_BITS = mode;
		POWERUP_TIMER_DISABLE_N = dis_n;
		cycles(8);
		RST = 0;
	endtask

	task automatic s_wake();
		SLEEP_ACTIVE = 1;
		cycles(1);
		SLEEP_ACTIVE = 0;
		SLEEP_WAKE = 1;
		cycles(1);
		SLEEP_WAKE = 0;
		cycles(2);
		chk("wake hold", 4'h2, {CHIP_RESET, REGISTER_RESET});
		wait_for(0, n);
		chk_n("wake start", n, 20400, 20540);
	endtask

	task automatic s_sleep();
		SLEEP_ACTIVE = 1;
		cycles(1);
		SLEEP_ACTIVE = 0;
		WATCHDOG_TIMEOUT = 1;
		cycles(1);
		WATCHDOG_TIMEOUT = 0;
		cycles(2);
		chk("watchdog wake", 4'h4, RESET_CAUSE);
		chk("wake kept", 4'h0, {CHIP_RESET, REGISTER_RESET,
			WATCHDOG_EXPIRED_FLAG, SLEEP_ENTERED_FLAG});
		SLEEP_ACTIVE = 1;
		cycles(1);
		SLEEP_ACTIVE = 0;
		clear_n = 0;
		cycles(10);
		chk("clear in sleep", 4'ha, {CHIP_RESET, RESET_CAUSE});
		chk("sleep flags", 4'h2,
			{WATCHDOG_EXPIRED_FLAG, SLEEP_ENTERED_FLAG});
		clear_n = 1;
		wait_for(0, n);
	endtask

	task automatic s_clock_output();
		logic last;
		int t;
		power_on(3'h7, 1);
		wait_for(0, n);
		chk("clock out enable", 4'h1, OSCILLATOR_OUTPUT_EN);
		last = OSCILLATOR_OUTPUT_PIN;
		t = 0;
		repeat (400)
		begin
			cycles(1);
			if (OSCILLATOR_OUTPUT_PIN !== last)
				t++;
			last = OSCILLATOR_OUTPUT_PIN;
		end
		chk_n("clock out toggles", t, 9, 11);
	endtask

	task automatic s_modes();
		for (int m = 0; m < 8; m++)
		begin
			power_on(m[2:0], 0);
			wait_for(0, n);
			if (m < 3)
				chk_n("crystal start", n, PU + 20460, PU + 20540);
			else
				chk_n("timer start", n, PU, PU + 15);
			if (m == 2)
				s_wake();
		end
		power_on(3'h6, 1);
		wait_for(0, n);
		chk_n("no time-out start", n, 1, 15);
		chk("cause", 4'h0, RESET_CAUSE);
		chk("flags", 4'hc, {WATCHDOG_EXPIRED_FLAG, SLEEP_ENTERED_FLAG,
			POWER_ON_STATUS, REGISTER_RESET});
	endtask

	task automatic s_clear();
		clear_n = 0;
		power_on(3'h6, 0);
		cycles(PU + 40);
		chk("held reset", 4'h1, CHIP_RESET);
		clear_n = 1;
		wait_for(0, n);
		chk_n("release start", n, 1, 10);
		clear_n = 0;
		cycles(2);
		clear_n = 1;
		cycles(20);
		chk("glitch", 4'h0, CHIP_RESET);
		clear_n = 0;
		cycles(10);
		chk("clear reset", 4'h9, {CHIP_RESET, RESET_CAUSE});
		clear_n = 1;
		wait_for(0, n);
		WATCHDOG_TIMEOUT = 1;
		cycles(1);
		WATCHDOG_TIMEOUT = 0;
		cycles(4);
		chk("watchdog", 4'h3, {WATCHDOG_EXPIRED_FLAG, RESET_CAUSE});
		wait_for(0, n);
	endtask

	task automatic s_brownout();
		STATUS_WRITE = 1;
		POWER_ON_STATUS_VALUE = 1;
		BROWNOUT_STATUS_VALUE = 1;
		cycles(1);
		STATUS_WRITE = 0;
		cycles(1);
		chk("status write", 4'h3, {POWER_ON_STATUS, BROWNOUT_STATUS});
		supply_ok = 0;
		cycles(20);
		chk("detector off", 4'h0, CHIP_RESET);
		supply_ok = 1;
		BROWNOUT_ENABLE = 1;
		cycles(5);
		supply_ok = 0;
		cycles(12);
		chk("brown-out", 4'hd, {CHIP_RESET, RESET_CAUSE});
		chk("status", 4'h2, {POWER_ON_STATUS, BROWNOUT_STATUS});
		chk("status kept", 4'h1, POWER_ON_STATUS);
		supply_ok = 1;
		cycles(PU / 2);
		supply_ok = 0;
		cycles(10);
		supply_ok = 1;
		wait_for(0, n);
		chk_n("timer restart", n, PU, PU + 15);
		BROWNOUT_ENABLE = 0;
	endtask

	task automatic s_speed();
		power_on(3'h4, 1);
		wait_for(0, n);
		wait_for(1, n);
		wait_for(1, n);
		chk_n("fast tick", n, FAST_DIVIDE, FAST_DIVIDE);
		SPEED_SELECT_VALUE = 0;
		SPEED_SELECT_WRITE = 1;
		cycles(1);
		SPEED_SELECT_WRITE = 0;
		wait_for(1, n);
		chk_n("halt", n, 8 * SLOW_DIVIDE, 2 * FAST_DIVIDE + 9 * SLOW_DIVIDE);
		wait_for(1, n);
		chk_n("slow tick", n, SLOW_DIVIDE, SLOW_DIVIDE);
		chk("flag", 4'h0, SPEED_SELECT_FLAG);
		cycles(10);
		OSCILLATOR_SELECT_BITS = 3'h6;
		SPEED_SELECT_VALUE = 1;
		SPEED_SELECT_WRITE = 1;
		cycles(1);
		SPEED_SELECT_WRITE = 0;
		cycles(3);
		chk("refused", 4'h0, SPEED_SELECT_FLAG);
	endtask

	initial
	begin
		cycles(1);
		s_modes();
		s_clear();
		s_sleep();
		s_brownout();
		s_speed();
		s_clock_output();
		end_of_test();
	end
endmodule
`default_nettype wire
